//--- core/vsc_consts.svh
// Constants for the video serial transfer controller
//
// Summary of operation
// - First serial bit needs shift clock rise
// - Column bits pick tap, bit eight half
// - Gate held low at row strobe fall
// - Full transfer precedes first split transfer
// - Serial access may start after full transfer
// - Split waits after half's last bit
// - Row strobe rise precedes last bit; not enforced, a split is only kept from starting during the guard after the last bit
`ifndef VSC_CONSTS_SVH
`define VSC_CONSTS_SVH
// Register byte offsets
`define VSC_REG_CMD 8'h00
`define VSC_REG_ADDR 8'h04
`define VSC_REG_STAT 8'h08
`define VSC_REG_DATA 8'h0c
`define VSC_REG_COUNT 8'h10
// Command field positions
`define VSC_CMD_OP_LSB 0
`define VSC_CMD_OP_MSB 2
`define VSC_CMD_SE_BIT 4
// Status bit positions
`define VSC_ST_BUSY 0
`define VSC_ST_INIT 1
`define VSC_ST_ERR 2
`define VSC_ST_DVALID 3
// Reset values
`define VSC_CMD_RST 32'h0000_0010
`define VSC_ADDR_RST 32'h0000_0000
// Strobe phase length in ns and in mclk cycles
`define VSC_PHASE_NS 40
`define VSC_PHASE_CYC ((`VSC_PHASE_NS + 9) / 10)
// Split-transfer guard delay in link cycles
`define VSC_MSRL_CYC 4
// Last bit positions of both halves
`define VSC_LAST_LO 8'h7f
`define VSC_LAST_HI 8'hff
`endif

//--- core/vsc_pkg.sv
// Types of the video serial transfer controller
package vsc_pkg;
   // Commands written by software
   typedef enum logic [2:0] {
      VSC_OP_NONE = 3'b000,
      VSC_OP_FULL = 3'b001,
      VSC_OP_SPLIT = 3'b010,
      VSC_OP_REF_RESET = 3'b011,
      VSC_OP_REF_KEEP = 3'b100,
      VSC_OP_REF_STOP = 3'b101,
      VSC_OP_SHIFT = 3'b110
   } vsc_op_t;
   // Strobe sequencer states
   typedef enum logic [2:0] {
      VSC_IDLE = 3'b000,
      VSC_ROW = 3'b001,
      VSC_COL = 3'b010,
      VSC_HOLD = 3'b011,
      VSC_PRE = 3'b100
   } vsc_state_t;
endpackage : vsc_pkg

//--- core/vsc_serial_link.sv
// Serial shift clock side: pulses and samples in link domain
`timescale 1ns/1ps
module vsc_serial_link
   import vsc_pkg::*;
(
   input wire logic linkClk,
   input wire logic reset,
   input wire logic reqToggle,
   input wire logic [15:0] serialInPins,
   output logic ackToggle,
   output logic shiftClock,
   output logic [15:0] sampleData,
   output logic [7:0] bitCount
);
   // Reset passed into the link domain
   logic rstMeta_r;
   logic rstSync_r;
   // Request toggle synchroniser
   logic reqMeta_r;
   logic reqSync_r;
   logic reqSeen_r;
   // Shift phase: 0 idle, 1 clock high, 2 and 3 let the new word pass the synchroniser
   logic [1:0] phase_r;
   // Serial data synchroniser
   logic [15:0] dataMeta_r;
   logic [15:0] dataSync_r;
   // New request pending
   wire reqNew = reqSync_r ^ reqSeen_r;

   // Synchronisers
   always_ff @(posedge linkClk) begin
      rstMeta_r <= reset;
      rstSync_r <= rstMeta_r;
      reqMeta_r <= reqToggle;
      reqSync_r <= reqMeta_r;
      dataMeta_r <= serialInPins;
      dataSync_r <= dataMeta_r;
   end

   // One rising shift edge per request
   always_ff @(posedge linkClk) begin
      if (rstSync_r) begin
         reqSeen_r <= reqSync_r;
         phase_r <= 2'h0;
         shiftClock <= 1'b0;
         ackToggle <= 1'b0;
         sampleData <= 16'h0000;
         bitCount <= 8'h00;
      end else if (phase_r == 2'h1) begin
         // Fall; the new word is only in the first stage yet
         shiftClock <= 1'b0;
         phase_r <= 2'h2;
      end else if (phase_r == 2'h2) begin
         // Second stage takes the new word
         phase_r <= 2'h3;
      end else if (phase_r == 2'h3) begin
         // Word shown after the rise has passed both stages
         phase_r <= 2'h0;
         sampleData <= dataSync_r;
         bitCount <= bitCount + 8'h01;
         ackToggle <= ~ackToggle;
      end else if (reqNew) begin
         shiftClock <= 1'b1;
         phase_r <= 2'h1;
         reqSeen_r <= reqSync_r;
      end
   end
endmodule : vsc_serial_link

//--- core/vsc_controller.sv
// Host controller: strobes the video DRAM for transfers, refresh and serial reads
`timescale 1ns/1ps
`include "vsc_consts.svh"
module vsc_controller
   import vsc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic linkClk,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // DRAM pins
   output logic row_strobe_n,
   output logic column_strobe_n,
   output logic transfer_gate_n,
   output logic special_function,
   output logic [8:0] address,
   output logic serial_out_enable_n,
   output logic serial_shift_clock,
   input wire logic [15:0] serial_out_pins
);
   // Software registers
   logic [31:0] cmd_r;
   logic [31:0] addr_r;
   logic [31:0] data_r;
   logic dataValid_r;
   logic err_r;
   logic initDone_r;
   // Write channel holding
   logic awHave_r;
   logic wHave_r;
   logic [7:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r; // Byte lanes held with the data
   // Sequencer
   vsc_state_t state_r;
   vsc_state_t state_nxt;
   vsc_op_t op_r;
   logic [7:0] phaseCnt_r;
   // Serial crossing
   logic reqToggle_r;
   logic ackMeta_r;
   logic ackSync_r;
   logic ackSeen_r;
   logic shiftBusy_r;
   logic [15:0] linkData;
   logic [7:0] linkCount;
   logic linkAck;
   // Bit count taken with each answer; link values stand still by then
   logic [7:0] countSync_r;
   // Guard delay after a half's last bit, in mclk
   logic [7:0] guardCnt_r;

   // Legal split needs a prior full transfer
   function automatic logic opAllowed(input vsc_op_t op, input logic inited);
      opAllowed = (op != VSC_OP_SPLIT) || inited;
   endfunction : opAllowed

   // Write decode
   wire wrFire = awHave_r && wHave_r && !s_axi_bvalid;
   wire wrCmd = wrFire && (awAddr_r == `VSC_REG_CMD);
   wire wrAddr = wrFire && (awAddr_r == `VSC_REG_ADDR);
   wire wrKnown = wrCmd || wrAddr;
   wire vsc_op_t newOp = vsc_op_t'(wData_r[`VSC_CMD_OP_MSB:`VSC_CMD_OP_LSB]);
   wire busy = (state_r != VSC_IDLE) || shiftBusy_r;
   wire startOk = wrCmd && !busy && (newOp != VSC_OP_NONE) && opAllowed(newOp, initDone_r);
   wire startBad = wrCmd && (busy || !opAllowed(newOp, initDone_r));
   wire isShift = startOk && (newOp == VSC_OP_SHIFT);
   wire isStrobe = startOk && !isShift;
   // Split written during guard after last bit does not start
   wire guardOk = (guardCnt_r == 8'h00);
   wire phaseDone = (phaseCnt_r == 8'h00);
   wire ackNew = ackSync_r ^ ackSeen_r;
   // Read decode
   wire [31:0] status = {28'h0, dataValid_r, err_r, initDone_r, busy};
   wire [31:0] rdMux = (s_axi_araddr == `VSC_REG_CMD) ? cmd_r :
      (s_axi_araddr == `VSC_REG_ADDR) ? addr_r :
      (s_axi_araddr == `VSC_REG_STAT) ? status :
      (s_axi_araddr == `VSC_REG_DATA) ? data_r :
      (s_axi_araddr == `VSC_REG_COUNT) ? {24'h0, countSync_r} : 32'h0;
   wire rdKnown = (s_axi_araddr == `VSC_REG_CMD) || (s_axi_araddr == `VSC_REG_ADDR) ||
      (s_axi_araddr == `VSC_REG_STAT) || (s_axi_araddr == `VSC_REG_DATA) ||
      (s_axi_araddr == `VSC_REG_COUNT);
   // Op in force: the starting command on the entry edge, the latched one after it
   wire vsc_op_t curOp = (state_r == VSC_IDLE) ? newOp : op_r;
   // Refresh codes on gate and function pins; the latched op still holds the
   // previous command on the entry edge and would open a refresh as a transfer
   wire refOp = (curOp == VSC_OP_REF_RESET) || (curOp == VSC_OP_REF_KEEP) || (curOp == VSC_OP_REF_STOP);
   // Byte-lane merge of a write into the old register value
   wire [31:0] cmdMerged = laneMerge(cmd_r, wData_r, wStrb_r);
   wire [31:0] addrMerged = laneMerge(addr_r, wData_r, wStrb_r);

   // Address and data capture, either order
   always_ff @(posedge mclk) begin
      if (reset) begin
         awHave_r <= 1'b0;
         wHave_r <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r <= 32'h0;
         wStrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !awHave_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHave_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_r <= 1'b1;
            awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
         end else if (wrFire) begin
            awHave_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end else if (wrFire) begin
            wHave_r <= 1'b0;
         end
      end
   end

   // Write response
   // Unmapped offsets answer with a slave error
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrKnown ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel, one cycle to answer
   // Address is decoded straight from the bus while arvalid stands
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdKnown ? 2'b00 : 2'b10;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Command, address and error registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         cmd_r <= `VSC_CMD_RST;
         addr_r <= `VSC_ADDR_RST;
         err_r <= 1'b0;
      end else begin
         // Unstrobed lanes keep their old value
         if (wrCmd && !busy) cmd_r <= cmdMerged;
         if (wrAddr && !busy) addr_r <= {23'h0, addrMerged[8:0]};
         // Set beats clear: refusal flags stay until next good start
         if (startBad || (wrAddr && busy)) err_r <= 1'b1;
         else if (startOk) err_r <= 1'b0;
      end
   end

   // Byte-lane merge: only strobed lanes take the new value
   function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] lanes);
      logic [31:0] m;
      m = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
      laneMerge = (old & ~m) | (wr & m);
   endfunction : laneMerge

   // Next strobe state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         VSC_IDLE: if (isStrobe && (newOp != VSC_OP_SPLIT || guardOk)) state_nxt = VSC_ROW;
         VSC_ROW: if (phaseDone) state_nxt = VSC_COL;
         VSC_COL: if (phaseDone) state_nxt = VSC_HOLD;
         VSC_HOLD: if (phaseDone) state_nxt = VSC_PRE;
         VSC_PRE: if (phaseDone) state_nxt = VSC_IDLE;
         default: state_nxt = VSC_IDLE;
      endcase
   end

   // Sequencer and phase timer
   // Every phase lasts the same count; the timer reloads on each state change
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r <= VSC_IDLE;
         op_r <= VSC_OP_NONE;
         phaseCnt_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         if (state_r == VSC_IDLE && state_nxt == VSC_ROW) op_r <= newOp;
         if (state_nxt != state_r) phaseCnt_r <= 8'(`VSC_PHASE_CYC - 1);
         else if (!phaseDone) phaseCnt_r <= phaseCnt_r - 8'h01;
      end
   end

   // Pin drive. Transfer: gate low at row fall; refresh: column before row
   // Pins follow the next state so they move on the same edge as the state
   always_ff @(posedge mclk) begin
      if (reset) begin
         row_strobe_n <= 1'b1;
         column_strobe_n <= 1'b1;
         transfer_gate_n <= 1'b1;
         special_function <= 1'b0;
         address <= 9'h000;
         serial_out_enable_n <= 1'b1;
         initDone_r <= 1'b0;
      end else begin
         serial_out_enable_n <= cmd_r[`VSC_CMD_SE_BIT];
         unique case (state_nxt)
            VSC_IDLE: begin
               row_strobe_n <= 1'b1;
               column_strobe_n <= 1'b1;
               transfer_gate_n <= 1'b1;
            end
            VSC_ROW: begin
               if (refOp) begin
                  // Option code on gate and function
                  column_strobe_n <= 1'b0;
                  // Third condition rides the gate: low only for a new stop point
                  transfer_gate_n <= (curOp != VSC_OP_REF_STOP);
                  // Both conditions high keep options
                  // Second condition rides the function pin: low only for option reset
                  special_function <= (curOp != VSC_OP_REF_RESET);
                  address <= addr_r[8:0];
               end else begin
                  transfer_gate_n <= 1'b0;
                  // Function pin high marks a split transfer
                  special_function <= (curOp == VSC_OP_SPLIT);
                  address <= addr_r[8:0];
                  row_strobe_n <= 1'b0;
               end
            end
            VSC_COL: begin
               row_strobe_n <= 1'b0;
               column_strobe_n <= 1'b0;
               // Tap in low bits, half in bit eight
               if (!refOp) address <= addr_r[8:0];
            end
            VSC_HOLD: begin
               // Gate rises before row strobe, early load
               transfer_gate_n <= 1'b1;
            end
            VSC_PRE: begin
               row_strobe_n <= 1'b1;
               column_strobe_n <= 1'b1;
               if (op_r == VSC_OP_FULL) initDone_r <= 1'b1;
            end
            default: row_strobe_n <= 1'b1;
         endcase
      end
   end

   // Shift request and answer crossing
   always_ff @(posedge mclk) begin
      if (reset) begin
         reqToggle_r <= 1'b0;
         ackMeta_r <= 1'b0;
         ackSync_r <= 1'b0;
         ackSeen_r <= 1'b0;
         shiftBusy_r <= 1'b0;
         countSync_r <= 8'h00;
      end else begin
         // Only the toggle is synchronised; word and count are held behind it
         ackMeta_r <= linkAck;
         ackSync_r <= ackMeta_r;
         // Shifts allowed whenever not busy after reset, no transfer needed first
         if (isShift) begin
            reqToggle_r <= ~reqToggle_r;
            shiftBusy_r <= 1'b1;
         end else if (ackNew) begin
            ackSeen_r <= ackSync_r;
            shiftBusy_r <= 1'b0;
            // Count has stood still since its toggle, safe to take whole
            countSync_r <= linkCount;
         end
      end
   end

   // Data word and guard timer
   always_ff @(posedge mclk) begin
      if (reset) begin
         data_r <= 32'h0;
         dataValid_r <= 1'b0;
         guardCnt_r <= 8'h00;
      end else begin
         if (ackNew) begin
            // Link word has stood still since its toggle, so no copy per bit stage
            data_r <= {16'h0000, linkData};
            dataValid_r <= 1'b1;
         end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `VSC_REG_DATA) begin
            dataValid_r <= 1'b0;
         end
         // Split strobe ends before half's last bit; here a split is only kept from starting during the guard after it
         // Limitation: counts bits since reset, so a tap other than zero moves the guard
         // Guard counts mclk; four link cycles fit inside twenty
         if (ackNew && (linkCount - 8'h01 == `VSC_LAST_LO || linkCount - 8'h01 == `VSC_LAST_HI))
            guardCnt_r <= 8'(`VSC_MSRL_CYC * 5);
         else if (!guardOk) guardCnt_r <= guardCnt_r - 8'h01;
      end
   end

   // Shift clock generator in link domain
   vsc_serial_link u_link (
      .linkClk(linkClk),
      .reset(reset),
      .reqToggle(reqToggle_r),
      .serialInPins(serial_out_pins),
      .ackToggle(linkAck),
      .shiftClock(serial_shift_clock),
      .sampleData(linkData),
      .bitCount(linkCount)
   );
endmodule : vsc_controller

//--- bench/vsc_vram_model.sv
// Behavioural model of the video DRAM serial port
`timescale 1ns/1ps
module vsc_vram_model (
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic transfer_gate_n,
   input wire logic special_function,
   input wire logic [8:0] address,
   input wire logic serial_out_enable_n,
   input wire logic serial_shift_clock,
   output logic [15:0] serial_out_pins
);
   logic xferR = 1'b0; // Transfer cycle open
   logic loadedR = 1'b0; // Serial register holds data
   logic halfR = 1'b0; // Row half chosen
   logic [7:0] tapR = 8'h00; // Start tap
   logic [7:0] ptrR = 8'h00; // Next serial position
   logic [7:0] stopR = 8'hff; // Split stop point
   logic [15:0] wordR = 16'h0000; // Last word shifted
   logic [15:0] regR [256]; // Serial register
   int xferCount = 0; // Completed loads
   // Row fall decides transfer or refresh
   always @(negedge row_strobe_n) begin
      xferR = !transfer_gate_n && column_strobe_n;
      // reset option: function pin low, gate high
      if (!column_strobe_n && transfer_gate_n && !special_function) stopR = 8'hff;
      // new stop point: function high, gate low; both high leaves all
      if (!column_strobe_n && !transfer_gate_n && special_function) stopR = address[7:0];
   end
   always @(negedge column_strobe_n) begin
      if (xferR) begin
         tapR = address[7:0];
         halfR = address[8];
      end
   end
   // load on gate rise, no data pins here, late load accepted too
   always @(posedge transfer_gate_n) begin
      if (xferR) begin
         for (int i = 0; i < 256; i++) regR[i] = {3'b101, halfR, 4'h0, 8'(i)};
         ptrR = tapR;
         loadedR = 1'b1;
         xferR = 1'b0;
         xferCount++;
      end
   end
   // Each shift clock rise presents the next word
   always @(posedge serial_shift_clock) begin
      if (loadedR) begin
         wordR = regR[ptrR];
         ptrR = ptrR + 8'h01;
      end
   end
   // driven only when enabled, else inverted so stale data never matches
   assign serial_out_pins = (!serial_out_enable_n && loadedR) ? wordR : ~wordR;
endmodule : vsc_vram_model

//--- bench/vsc_controller_chk.sv
// Port checker of the video serial transfer controller
`timescale 1ns/1ps
module vsc_controller_chk (
   input wire logic mclk,
   input wire logic reset,
   input wire logic linkClk,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic transfer_gate_n,
   input wire logic serial_shift_clock
);
   logic xfer_r; // Transfer cycle under way
   // Marks row cycles opened with gate low
   always_ff @(posedge mclk) begin
      if (reset) xfer_r <= 1'b0;
      else if ($fell(row_strobe_n)) xfer_r <= !transfer_gate_n;
      else if (row_strobe_n) xfer_r <= 1'b0;
   end
   AST_RD_ANSWER: assert property (@(posedge mclk) disable iff (reset)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   AST_BRESP_HOLD: assert property (@(posedge mclk) disable iff (reset)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   AST_RDATA_HOLD: assert property (@(posedge mclk) disable iff (reset)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   AST_PHASE: assert property (@(posedge mclk) disable iff (reset)
      $fell(row_strobe_n) |-> !row_strobe_n [*4]) else $error("row phase short");
   AST_XFER_SEQ: assert property (@(posedge mclk) disable iff (reset)
      $fell(row_strobe_n) && !transfer_gate_n |-> ##[3:5] !column_strobe_n) else $error("column late");
   AST_GATE_AT_COL: assert property (@(posedge mclk) disable iff (reset)
      $fell(column_strobe_n) && xfer_r |-> !transfer_gate_n) else $error("gate high at column");
   AST_EARLY_LOAD: assert property (@(posedge mclk) disable iff (reset)
      $rose(row_strobe_n) && xfer_r |-> transfer_gate_n) else $error("gate after row");
   AST_SHIFT_PULSE: assert property (@(posedge linkClk) disable iff (reset)
      $rose(serial_shift_clock) |=> !serial_shift_clock) else $error("shift pulse long");
   COV_XFER: cover property (@(posedge mclk) disable iff (reset) $fell(row_strobe_n) && !transfer_gate_n);
   COV_REFRESH: cover property (@(posedge mclk) disable iff (reset) $fell(row_strobe_n) && !column_strobe_n);
   COV_SHIFT: cover property (@(posedge linkClk) disable iff (reset) $rose(serial_shift_clock));
endmodule : vsc_controller_chk
bind vsc_controller vsc_controller_chk chk_u (.mclk(mclk), .reset(reset), .linkClk(linkClk),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .row_strobe_n(row_strobe_n),
   .column_strobe_n(column_strobe_n), .transfer_gate_n(transfer_gate_n),
   .serial_shift_clock(serial_shift_clock));

//--- bench/test_vram_serial_transfer_control.sv
// Self-checking bench of the video serial transfer controller
`timescale 1ns/1ps
`include "vsc_consts.svh"
module test_vram_serial_transfer_control import vsc_pkg::*;;
   logic mclk = 1'b0, reset = 1'b1, linkClk = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf; // Whole words only
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, lastBresp;
   logic row_strobe_n, column_strobe_n, transfer_gate_n, special_function;
   logic serial_out_enable_n, serial_shift_clock;
   logic [8:0] address;
   logic [15:0] serial_out_pins;
   logic [31:0] d;
   logic [1:0] r;
   int errors = 0, cmp_count = 0, cycles = 0;
   vsc_controller dut_u (.*);
   vsc_vram_model vram_u (.*);
   // Two unrelated clocks
   initial forever #5 mclk = ~mclk;
   initial begin
      #3;
      forever #24 linkClk = ~linkClk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Write with address and data offered together
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      logic awDone, wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(awDone && wDone)) begin
         @(posedge mclk);
         if (!awDone && s_axi_awready === 1'b1) begin
            awDone = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wDone && s_axi_wready === 1'b1) begin
            wDone = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge mclk);
      lastBresp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   // Poll busy; the timeout ends a hang
   task automatic wait_idle;
      logic [31:0] s;
      logic [1:0] rs;
      do axi_rd(`VSC_REG_STAT, s, rs); while (s[`VSC_ST_BUSY] !== 1'b0);
   endtask : wait_idle
   task automatic run_cmd(input vsc_op_t op, input logic seN);
      wait_idle;
      axi_wr(`VSC_REG_CMD, {27'h0, seN, 1'b0, op});
      wait_idle;
   endtask : run_cmd
   task automatic test_reset;
      axi_rd(`VSC_REG_CMD, d, r);
      chk(d, `VSC_CMD_RST);
      axi_rd(`VSC_REG_ADDR, d, r);
      chk(d, `VSC_ADDR_RST);
      chk({31'h0, serial_out_enable_n}, 32'h1);
      axi_rd(8'h20, d, r);
      chk({30'h0, r}, 32'h2);
      chk(d, 32'h0);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_refuse;
      run_cmd(VSC_OP_SPLIT, 1'b1);
      chk({30'h0, lastBresp}, 32'h0);
      axi_rd(`VSC_REG_STAT, d, r);
      chk({31'h0, d[`VSC_ST_ERR]}, 32'h1);
      chk(vram_u.xferCount, 0);
      $display("test_refuse done");
   endtask : test_refuse
   // Upper half, tap 5, then two words and a disabled shift
   task automatic test_full;
      axi_wr(`VSC_REG_ADDR, 32'h0000_0105);
      run_cmd(VSC_OP_FULL, 1'b0);
      chk({31'h0, serial_out_enable_n}, 32'h0);
      for (int i = 0; i < 2; i++) begin
         run_cmd(VSC_OP_SHIFT, 1'b0);
         axi_rd(`VSC_REG_DATA, d, r);
         chk(d, 32'h0000_b005 + 32'(i));
         axi_rd(`VSC_REG_COUNT, d, r);
         chk(d, 32'(i + 1));
      end
      run_cmd(VSC_OP_SHIFT, 1'b1);
      axi_rd(`VSC_REG_DATA, d, r);
      chk(d, 32'h0000_4ff8);
      chk({31'h0, serial_out_enable_n}, 32'h1);
      run_cmd(VSC_OP_SPLIT, 1'b0);
      chk(vram_u.xferCount, 2);
      $display("test_full done");
   endtask : test_full
   task automatic test_refresh;
      vsc_op_t ops [3];
      logic [7:0] exps [3];
      ops = '{VSC_OP_REF_STOP, VSC_OP_REF_KEEP, VSC_OP_REF_RESET};
      exps = '{8'h3c, 8'h3c, 8'hff};
      axi_wr(`VSC_REG_ADDR, 32'h0000_003c);
      for (int i = 0; i < 3; i++) begin
         run_cmd(ops[i], 1'b0);
         chk({24'h0, vram_u.stopR}, {24'h0, exps[i]});
      end
      $display("test_refresh done");
   endtask : test_refresh
   task automatic finish_test;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   // Hang guard well above the expected run
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         errors++;
         finish_test;
      end
   end
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      test_reset;
      test_refuse;
      test_full;
      test_refresh;
      finish_test;
   end
endmodule : test_vram_serial_transfer_control
